// File: hdl/tevf_event_block.sv
/*
 * Event flags, software event generation and interrupt/DMA requests of
 * a four-channel timer, with an Avalon-MM register slave.
 * Assumes counter, channel and shadow logic elsewhere in the timer act
 * on the one-cycle strobes driven here; break and trigger are pins.
 */
`timescale 1ns/1ps

// ==========================================================
// Top module
module tevf_event_block #(
    parameter logic BREAK_ACTIVE = 1'b1
) (
    input  wire logic                        mclk,
    input  wire logic                        reset_n,
    input  wire logic [tevf_pkg::ADDR_W-1:0] address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [3:0]                  byteenable,
    input  wire logic [31:0]                 writedata,
    output logic      [31:0]                 readdata,
    output logic                             waitrequest,
    input  wire logic                        update_event,
    input  wire logic [tevf_pkg::NUM_CHAN-1:0] chan_event,
    input  wire logic                        commutation_event,
    input  wire logic                        break_pin,
    input  wire logic                        trigger_pin,
    output logic                             irq,
    output logic      [tevf_pkg::REQ_W-1:0]  dma_req,
    output logic                             counter_clear,
    output logic                             counter_load,
    output logic                             prescaler_clear,
    output logic      [tevf_pkg::NUM_CHAN-1:0] capture_strobe,
    output logic                             shadow_transfer,
    output logic                             shadow_update_select,
    output logic                             primary_output_enable,
    output logic                             counter_clock_enable
);
    import tevf_pkg::*;

    logic [EN_W-1:0]     irq_dma_enables;
    logic [CFG_W-1:0]    timer_config;
    logic [FLAG_W-1:0]   event_flags;
    logic [FLAG_W-1:0]   flag_set;
    logic [FLAG_W-1:0]   flag_clr;
    logic [GEN_W-1:0]    sw_gen;
    logic                break_s1;
    logic                break_s2;
    logic                trig_s1;
    logic                trig_s2;
    logic                trig_q;
    logic                trig_edge;
    logic                break_active;
    logic                pause_mode;
    logic                accept;
    logic                wr_acc;
    logic [NUM_CHAN-1:0] chan_input;
    logic                count_down;
    logic [31:0]         next_readdata;

    assign pause_mode = timer_config[CFG_SMS_LSB +: 3] == SMS_PAUSE;
    assign chan_input = timer_config[CFG_INPUT_LSB +: NUM_CHAN];
    assign count_down = timer_config[CFG_COUNT_DOWN];
    assign accept     = (read || write) && !waitrequest;
    assign wr_acc     = write && !waitrequest;

    // ==========================================================
    // Pin synchronisers
    // Break and trigger come from pins; the second stage is used, and trig_q, a third stage, for trigger edges
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            break_s1 <= 1'b0;
            break_s2 <= 1'b0;
            trig_s1  <= 1'b0;
            trig_s2  <= 1'b0;
            trig_q   <= 1'b0;
        end else begin
            break_s1 <= break_pin;
            break_s2 <= break_s1;
            trig_s1  <= trigger_pin;
            trig_s2  <= trig_s1;
            trig_q   <= trig_s2;
        end
    end

    assign break_active = break_s2 == BREAK_ACTIVE;
    // Pause mode reacts to both edges, other modes to the rising edge
    assign trig_edge = pause_mode ? (trig_s2 ^ trig_q) : (trig_s2 && !trig_q);

    // ==========================================================
    // Bus slave
    // One wait state: the read word is staged while waitrequest is high
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // Read mux; unmapped offsets and the generation register read zero
    always_comb begin
        next_readdata = WORD_ZERO;
        case (address)
            OFF_IRQ_DMA_EN:   next_readdata[EN_W-1:0] = irq_dma_enables;
            OFF_EVENT_FLAGS:  next_readdata[FLAG_W-1:0] = event_flags;
            OFF_SOFT_EVENT:   next_readdata = WORD_ZERO;
            OFF_TIMER_CONFIG: begin
                next_readdata[CFG_W-1:0] = timer_config;
                next_readdata[CFG_PRIMARY_OUTPUT_ENABLE]  = primary_output_enable;
            end
            OFF_TIMER_STATUS: begin
                next_readdata[STAT_BREAK] = break_active;
                next_readdata[STAT_TRIG]  = trig_s2;
            end
            default:          next_readdata = WORD_ZERO;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            readdata <= WORD_ZERO;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // Enable and configuration registers, byte lanes honoured
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_dma_enables <= EN_RESET;
            timer_config    <= CFG_RESET;
        end else if (wr_acc) begin
            if (address == OFF_IRQ_DMA_EN) begin
                if (byteenable[0]) irq_dma_enables[7:0] <= writedata[7:0];
                if (byteenable[1]) irq_dma_enables[14:8] <= writedata[14:8];
            end
            if (address == OFF_TIMER_CONFIG) begin
                if (byteenable[0]) timer_config[7:0] <= writedata[7:0];
                if (byteenable[1]) timer_config[10:8] <= writedata[10:8];
            end
        end
    end

    // Primary output enable: software sets it, break clears it.
    // Break wins so a write racing a fault cannot re-arm the outputs.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            primary_output_enable <= 1'b0;
        end else if (sw_gen[BIT_BREAK] || break_active) begin
            primary_output_enable <= 1'b0;
        end else if (wr_acc && address == OFF_TIMER_CONFIG && byteenable[1]) begin
            primary_output_enable <= writedata[CFG_PRIMARY_OUTPUT_ENABLE];
        end
    end

    // Generation bits live one cycle only, then return to zero
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sw_gen <= '0;
        end else if (wr_acc && address == OFF_SOFT_EVENT && byteenable[0]) begin
            sw_gen <= writedata[GEN_W-1:0];
        end else begin
            sw_gen <= '0;
        end
    end

    // ==========================================================
    // Event flags
    // A written zero clears; a written one is ignored
    always_comb begin
        flag_clr = '0;
        if (wr_acc && address == OFF_EVENT_FLAGS) begin
            if (byteenable[0]) flag_clr[7:0] = ~writedata[7:0];
            if (byteenable[1]) flag_clr[12:8] = ~writedata[12:8];
        end
        flag_clr = flag_clr & FLAG_VALID;
    end

    // Set sources merge hardware events and software generation
    always_comb begin
        flag_set = '0;
        flag_set[BIT_UPDATE]  = update_event || sw_gen[BIT_UPDATE];
        flag_set[BIT_COMMUT]  = commutation_event || sw_gen[BIT_COMMUT];
        flag_set[BIT_TRIGGER] = trig_edge || sw_gen[BIT_TRIGGER];
        // Break level keeps setting the flag, so a clear only holds once inactive
        flag_set[BIT_BREAK]   = break_active || sw_gen[BIT_BREAK];
        for (int i = 0; i < NUM_CHAN; i++) begin
            flag_set[BIT_CHAN0+i] = chan_event[i] || sw_gen[BIT_CHAN0+i];
            // Over-capture looks at the flag before this capture lands
            flag_set[BIT_OVCAP0+i] = chan_input[i] && flag_set[BIT_CHAN0+i]
                                     && event_flags[BIT_CHAN0+i];
        end
    end

    // One cell per implemented flag; the reserved bit stays zero
    for (genvar g = 0; g < FLAG_W; g++) begin : g_flag
        if (FLAG_VALID[g]) begin : g_cell
            tevf_flag_cell u_cell (
                .mclk    (mclk),
                .reset_n (reset_n),
                .set     (flag_set[g]),
                .clear   (flag_clr[g]),
                .q       (event_flags[g])
            );
        end else begin : g_rsvd
            assign event_flags[g] = 1'b0;
        end
    end

    // ==========================================================
    // Requests and timer strobes
    // Interrupt is level while any enabled flag is set
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq     <= 1'b0;
            dma_req <= '0;
        end else begin
            irq     <= |(event_flags[7:0] & irq_dma_enables[7:0]);
            dma_req <= flag_set[REQ_W-1:0] & irq_dma_enables[DEN_LSB +: REQ_W];
        end
    end

    // Update generation: clear or reload counter, prescaler cleared alongside
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            counter_clear   <= 1'b0;
            counter_load    <= 1'b0;
            prescaler_clear <= 1'b0;
        end else begin
            counter_clear   <= sw_gen[BIT_UPDATE] && !count_down;
            counter_load    <= sw_gen[BIT_UPDATE] && count_down;
            prescaler_clear <= sw_gen[BIT_UPDATE];
        end
    end

    // Capture and shadow strobes for the channel logic
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            capture_strobe       <= '0;
            shadow_transfer      <= 1'b0;
            shadow_update_select <= 1'b0;
        end else begin
            capture_strobe       <= sw_gen[BIT_CHAN0 +: NUM_CHAN] & chan_input;
            shadow_transfer      <= sw_gen[BIT_COMMUT];
            shadow_update_select <= timer_config[CFG_SHADOW_SEL];
        end
    end

    // Counter clock gate; only pause mode looks at the trigger level
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            counter_clock_enable <= 1'b1;
        end else begin
            counter_clock_enable <= pause_mode ? trig_s2 : 1'b1;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_soft_reads_zero: assert property (
        (read && waitrequest && address == OFF_SOFT_EVENT) |=> readdata == WORD_ZERO)
        else $error("generation register read not zero");
    a_gen_self_clear: assert property (
        (sw_gen != '0) |=> (sw_gen == '0) || $past(wr_acc))
        else $error("generation bits held");
    a_update_flag: assert property (
        update_event |=> event_flags[BIT_UPDATE])
        else $error("update flag not set");
    a_chan_flag: assert property (
        chan_event[0] |=> event_flags[BIT_CHAN0])
        else $error("channel flag not set");
    a_overcapture_set: assert property (
        (chan_event[2] && chan_input[2] && event_flags[BIT_CHAN0+2])
        |=> event_flags[BIT_OVCAP0+2])
        else $error("over-capture missed");
    a_no_overcap_out: assert property (
        (!event_flags[BIT_OVCAP0] && !chan_input[0] && !flag_clr[BIT_OVCAP0])
        |=> !event_flags[BIT_OVCAP0])
        else $error("over-capture in output mode");
    a_break_level: assert property (
        break_active [*2] |=> event_flags[BIT_BREAK])
        else $error("break flag not held");
    a_trigger_pause: assert property (
        (pause_mode && $fell(trig_s2)) |=> event_flags[BIT_TRIGGER])
        else $error("pause falling edge missed");
    a_commut_flag: assert property (
        commutation_event |=> event_flags[BIT_COMMUT])
        else $error("commutation flag not set");
    a_break_gen: assert property (
        sw_gen[BIT_BREAK] |=> !primary_output_enable && event_flags[BIT_BREAK])
        else $error("break generation ineffective");
    a_trig_gen: assert property (
        (sw_gen[BIT_TRIGGER] && irq_dma_enables[DEN_LSB+BIT_TRIGGER])
        |=> event_flags[BIT_TRIGGER] && dma_req[BIT_TRIGGER])
        else $error("trigger generation ineffective");
    a_shadow_xfer: assert property (
        sw_gen[BIT_COMMUT] |=> shadow_transfer ##1 !shadow_transfer || $past(sw_gen[BIT_COMMUT]))
        else $error("shadow transfer not one pulse");
    a_soft_capture: assert property (
        (sw_gen[BIT_CHAN0+1] && chan_input[1])
        |=> capture_strobe[1] && event_flags[BIT_CHAN0+1])
        else $error("software capture missed");
    a_soft_overcap: assert property (
        (sw_gen[BIT_CHAN0+3] && chan_input[3] && event_flags[BIT_CHAN0+3])
        |=> event_flags[BIT_OVCAP0+3])
        else $error("software over-capture missed");
    a_update_gen: assert property (
        sw_gen[BIT_UPDATE] |=> counter_load == $past(count_down)
        && counter_clear == !$past(count_down))
        else $error("update generation wrong counter action");
    a_prescale_clr: assert property (
        (counter_clear || counter_load) |-> prescaler_clear)
        else $error("prescaler not cleared with counter");
    a_irq_enable: assert property (
        ((event_flags[7:0] & irq_dma_enables[7:0]) == '0) |=> !irq)
        else $error("interrupt without enabled flag");
    a_pause_gate: assert property (
        pause_mode |=> counter_clock_enable == $past(trig_s2))
        else $error("pause gate wrong");
    a_write_one_keep: assert property (
        (wr_acc && address == OFF_EVENT_FLAGS && byteenable[0] && writedata[BIT_COMMUT]
         && event_flags[BIT_COMMUT]) |=> event_flags[BIT_COMMUT])
        else $error("write one cleared a flag");
    a_set_beats_clr: assert property (
        (update_event && flag_clr[BIT_UPDATE]) |=> event_flags[BIT_UPDATE])
        else $error("clear beat hardware set");

    c_break_gen: cover property (sw_gen[BIT_BREAK] ##1 event_flags[BIT_BREAK]);
    c_overcapture: cover property ($rose(event_flags[BIT_OVCAP0]));
    c_race: cover property (flag_set[BIT_UPDATE] && flag_clr[BIT_UPDATE]);
    c_pause_edge: cover property (pause_mode && $fell(trig_s2));
endmodule : tevf_event_block

// File: pkg/tevf_pkg.sv
/*
 * Constants of the timer event-flag and software-event block: register
 * offsets, field positions, reset values and the slave-mode code.
 * Assumes byte addressing on an Avalon-MM bus with 32-bit data.
 */
// Operation
// - Capture on input channel with flag already set sets its over-capture flag, bits 9-12.
// - Active break input level sets the break flag, bit 7.
// - Trigger event sets bit 6; pause mode counts both trigger edges.
// - Commutation event sets bit 5, held until software clears it.
// - Capture (input) or compare match (output) sets channel flag, bits 1-4.
// - Update event sets bit 0, held until software clears it.
// - Generation bits self-clear after the event; reads always show zero.
// - Break generation clears primary output enable and sets the break flag.
// - Trigger generation sets the trigger flag and its request.
// - Commutation generation transfers channel shadow controls per shadow select.
// - Channel generation sets channel flag; input mode captures the counter.
// - Generated capture sets over-capture when channel flag was already set.
// - Update generation clears counter counting up, reloads it counting down.
// - Update generation clears the prescaler together with the counter.
// - Flags raise interrupt or DMA only when their enable at 0x0C is set.
// - Pause slave mode 101 gates counter clock with the trigger level.

// ==========================================================
// Package
package tevf_pkg;
    localparam int         ADDR_W           = 8;
    localparam int         NUM_CHAN         = 4;
    localparam int         FLAG_W           = 13;
    localparam int         REQ_W            = 7;
    localparam int         EN_W             = 15;
    localparam int         CFG_W            = 11;

    // Register byte offsets
    localparam logic [7:0] OFF_IRQ_DMA_EN   = 8'h0c;
    localparam logic [7:0] OFF_EVENT_FLAGS  = 8'h10;
    localparam logic [7:0] OFF_SOFT_EVENT   = 8'h14;
    localparam logic [7:0] OFF_TIMER_CONFIG = 8'h20;
    localparam logic [7:0] OFF_TIMER_STATUS = 8'h24;

    // Flag and generation bit positions
    localparam int         BIT_UPDATE       = 0;
    localparam int         BIT_CHAN0        = 1;
    localparam int         BIT_COMMUT       = 5;
    localparam int         BIT_TRIGGER      = 6;
    localparam int         BIT_BREAK        = 7;
    localparam int         BIT_OVCAP0       = 9;
    localparam int         GEN_W            = 8;
    localparam int         DEN_LSB          = 8;
    localparam logic [12:0] FLAG_VALID      = 13'h1eff;

    // Timer configuration fields
    localparam int         CFG_SMS_LSB      = 0;
    localparam int         CFG_INPUT_LSB    = 4;
    localparam int         CFG_COUNT_DOWN   = 8;
    localparam int         CFG_SHADOW_SEL   = 9;
    localparam int         CFG_PRIMARY_OUTPUT_ENABLE         = 10;
    localparam int         STAT_BREAK       = 0;
    localparam int         STAT_TRIG        = 1;
    localparam logic [2:0] SMS_PAUSE        = 3'h5;

    // Reset values
    localparam logic [14:0] EN_RESET        = 15'h0000;
    localparam logic [10:0] CFG_RESET       = 11'h000;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
endpackage : tevf_pkg

// File: hdl/tevf_flag_cell.sv
/*
 * One sticky event flag: set by an event, cleared by software.
 * Assumes set and clear come from logic on mclk.
 */
`timescale 1ns/1ps

// ==========================================================
// Flag cell
module tevf_flag_cell (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic set,
    input  wire logic clear,
    output logic      q
);
    // Set is tested first so a coinciding event is never lost
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clear) begin
            q <= 1'b0;
        end
    end
endmodule : tevf_flag_cell

// File: tb/tevf_event_block_bench.sv
/*
 * Self-checking bench of the timer event-flag block: hardware events,
 * software generation, interrupt and DMA requests, break and trigger pins.
 * Assumes the package constants and the one-wait-state Avalon-MM slave.
 */
`timescale 1ns/1ps

// ==========================================================
// Bench
module tevf_event_block_bench;
    import tevf_pkg::*;
    logic        mclk, reset_n, read, write, update_event, commutation_event;
    logic        break_pin, trigger_pin, irq, waitrequest, counter_clear, counter_load;
    logic        prescaler_clear, shadow_transfer, shadow_update_select;
    logic        primary_output_enable, counter_clock_enable, seen_clr;
    logic [7:0]  address;
    logic [3:0]  byteenable, chan_event, capture_strobe;
    logic [31:0] writedata, readdata, q;
    logic [6:0]  dma_req;
    logic [14:0] seen;
    logic [14:0] gexp [8] = '{15'h0005, 15'h0010, 15'h0020, 15'h0040,
                              15'h0080, 15'h0008, 15'h0000, 15'h0000};
    int          n_fail, cmp_count;

    tevf_event_block dut (.mclk(mclk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .update_event(update_event),
        .chan_event(chan_event), .commutation_event(commutation_event),
        .break_pin(break_pin), .trigger_pin(trigger_pin), .irq(irq), .dma_req(dma_req),
        .counter_clear(counter_clear), .counter_load(counter_load),
        .prescaler_clear(prescaler_clear), .capture_strobe(capture_strobe),
        .shadow_transfer(shadow_transfer), .shadow_update_select(shadow_update_select),
        .primary_output_enable(primary_output_enable),
        .counter_clock_enable(counter_clock_enable));

    // Clock, 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Sticky record of one-cycle strobes, so a pulse is never missed
    always @(posedge mclk) begin
        seen <= seen_clr ? 15'h0000 : seen | {dma_req, capture_strobe, shadow_transfer,
                                             prescaler_clear, counter_load, counter_clear};
    end

    // ==========================================================
    // Shared tasks
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon transfer; hw pulses update_event so it lands on the take edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic hw);
        int n;
        n = 0;
        @(posedge mclk);
        write     <= wr;
        read      <= !wr;
        address   <= a;
        writedata <= d;
        do begin
            @(posedge mclk);
            update_event <= hw && (n == 0);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        if (waitrequest !== 1'b0) begin
            n_fail++;
            results();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 1'b0);
        chk(q, exp);
    endtask : rd

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
    endtask : waitc

    task automatic pulse(input logic [5:0] v);
        @(posedge mclk);
        {commutation_event, chan_event, update_event} <= v;
        @(posedge mclk);
        {commutation_event, chan_event, update_event} <= 6'h00;
    endtask : pulse

    task automatic sclr;
        @(posedge mclk);
        seen_clr <= 1'b1;
        @(posedge mclk);
        seen_clr <= 1'b0;
    endtask : sclr

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(OFF_EVENT_FLAGS, 32'h0);
        rd(OFF_SOFT_EVENT, 32'h0);
        rd(8'h30, 32'h0);
        chk({irq, primary_output_enable, counter_clock_enable}, 32'h1);
    endtask : t_reset

    // All hardware events at once, then write-one keeps and write-zero clears
    task automatic t_hw;
        pulse(6'h3f);
        pulse(6'h1e);
        rd(OFF_EVENT_FLAGS, 32'h3f);
        wr(OFF_EVENT_FLAGS, 32'hffff_ffff);
        rd(OFF_EVENT_FLAGS, 32'h3f);
        wr(OFF_EVENT_FLAGS, 32'h3e);
        rd(OFF_EVENT_FLAGS, 32'h3e);
        wr(OFF_EVENT_FLAGS, 32'h0);
        wr(OFF_TIMER_CONFIG, 32'hf0);
        pulse(6'h1e);
        pulse(6'h1e);
        rd(OFF_EVENT_FLAGS, 32'h1e1e);
        wr(OFF_EVENT_FLAGS, 32'h0);
    endtask : t_hw

    // Every generation bit in turn, with its flag and side strobes
    task automatic t_gen;
        logic [31:0] acc;
        acc = 32'h0;
        wr(OFF_TIMER_CONFIG, 32'h4f0);
        // The write lands on the edge the bus task returns at; let it settle
        waitc(1);
        chk(primary_output_enable, 32'h1);
        for (int b = 0; b < GEN_W; b++) begin
            sclr();
            wr(OFF_SOFT_EVENT, 32'h1 << b);
            waitc(3);
            chk(seen, gexp[b]);
            acc = acc | (32'h1 << b);
            rd(OFF_EVENT_FLAGS, acc);
            rd(OFF_SOFT_EVENT, 32'h0);
        end
        chk(primary_output_enable, 32'h0);
        // Channels 0 and 3 generated again while their flags stand
        wr(OFF_SOFT_EVENT, 32'h12);
        rd(OFF_EVENT_FLAGS, 32'h12ff);
        wr(OFF_TIMER_CONFIG, 32'h3f0);
        sclr();
        wr(OFF_SOFT_EVENT, 32'h1);
        waitc(3);
        chk(seen, 32'h6);
        chk(shadow_update_select, 32'h1);
        wr(OFF_EVENT_FLAGS, 32'h0);
        wr(OFF_TIMER_CONFIG, 32'h0);
    endtask : t_gen

    // Interrupt raised, masked, unmasked, cleared; set beats clear
    task automatic t_irq;
        wr(OFF_IRQ_DMA_EN, 32'h7f01);
        sclr();
        pulse(6'h01);
        waitc(3);
        chk({irq, seen}, 32'h8100);
        wr(OFF_IRQ_DMA_EN, 32'h0);
        waitc(2);
        chk(irq, 32'h0);
        wr(OFF_IRQ_DMA_EN, 32'h1);
        waitc(2);
        chk(irq, 32'h1);
        bus(1'b1, OFF_EVENT_FLAGS, 32'h0, 1'b1);
        rd(OFF_EVENT_FLAGS, 32'h1);
        wr(OFF_EVENT_FLAGS, 32'h0);
        waitc(2);
        chk(irq, 32'h0);
    endtask : t_irq

    // Break pin: flag, output disable, clearing only once released
    task automatic t_break;
        wr(OFF_TIMER_CONFIG, 32'h400);
        @(posedge mclk);
        break_pin <= 1'b1;
        waitc(5);
        chk(primary_output_enable, 32'h0);
        rd(OFF_TIMER_STATUS, 32'h1);
        wr(OFF_EVENT_FLAGS, 32'h0);
        rd(OFF_EVENT_FLAGS, 32'h80);
        break_pin <= 1'b0;
        waitc(5);
        wr(OFF_EVENT_FLAGS, 32'h0);
        rd(OFF_EVENT_FLAGS, 32'h0);
    endtask : t_break

    // Trigger edges outside and inside pause mode, clock gating, DMA
    task automatic t_trig;
        trigger_pin <= 1'b1;
        waitc(5);
        wr(OFF_EVENT_FLAGS, 32'h0);
        trigger_pin <= 1'b0;
        waitc(5);
        rd(OFF_EVENT_FLAGS, 32'h0);
        wr(OFF_TIMER_CONFIG, {29'h0, SMS_PAUSE});
        waitc(3);
        chk(counter_clock_enable, 32'h0);
        trigger_pin <= 1'b1;
        waitc(5);
        chk(counter_clock_enable, 32'h1);
        wr(OFF_EVENT_FLAGS, 32'h0);
        trigger_pin <= 1'b0;
        waitc(5);
        rd(OFF_EVENT_FLAGS, 32'h40);
        wr(OFF_TIMER_CONFIG, 32'h0);
        wr(OFF_EVENT_FLAGS, 32'h0);
        wr(OFF_IRQ_DMA_EN, 32'h4000);
        sclr();
        wr(OFF_SOFT_EVENT, 32'h40);
        waitc(3);
        chk(seen, 32'h4000);
    endtask : t_trig

    // ==========================================================
    // Main sequence
    initial begin
        {reset_n, read, write, update_event, commutation_event} = 5'h00;
        {break_pin, trigger_pin, seen_clr, chan_event} = 7'h00;
        address    = 8'h00;
        writedata  = 32'h0;
        byteenable = 4'hf;
        n_fail     = 0;
        cmp_count  = 0;
        waitc(3);
        reset_n <= 1'b1;
        t_reset();
        t_hw();
        t_gen();
        t_irq();
        t_break();
        t_trig();
        results();
    end
endmodule : tevf_event_block_bench
